// ===== rtl/qio_pkg.sv
// Purpose: shared constants and types for the quad parallel i/o ports
// Assumes: APB register bus, 32-bit data, one aligned word per register
// Notes:   pin index is port*8+bit, port A = 0 .. port D = 3
package qio_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int unsigned QIO_PORTS = 4;
   localparam int unsigned QIO_BITS  = 8;
   localparam int unsigned QIO_PINS  = 32;
   localparam int unsigned QIO_REGS  = 9;

   // ----------------------------------------------------------------
   // register indices as printed, byte address is index times four
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_LATCH_BASE = 12'h000;  // four latches, consecutive
   localparam logic [11:0] IDX_DIR_BASE   = 12'h004;  // four directions, consecutive
   localparam logic [11:0] IDX_LED        = 12'h00c;
   localparam logic [11:0] OFF_LATCH_BASE = 12'(IDX_LATCH_BASE * 4);
   localparam logic [11:0] OFF_DIR_BASE   = 12'(IDX_DIR_BASE * 4);
   localparam logic [11:0] OFF_LED        = 12'(IDX_LED * 4);
   localparam logic [11:0] OFF_STEP       = 12'h004;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned LED_LSB  = 0;
   localparam int unsigned LED_W    = 6;
   localparam logic [7:0]  DIR_RST  = 8'h00;
   localparam logic [5:0]  LED_RST  = 6'h00;
   localparam logic [4:0]  ADC_CH_FIRST_A = 5'h00;  // channels 0..3 on port A 4..7
   localparam logic [4:0]  ADC_CH_FIRST_B = 5'h04;  // channels 4..5 on port B 6..7
   localparam logic [1:0]  ELS_GPIO = 2'h0;         // timer channel leaves the pin

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } qio_bus_e;

   typedef struct packed {
      logic [7:0]      kbi_en;    // keyboard_pin_enable, A0..A3 then D4..D7
      logic [4:0]      adc_sel;   // converter_channel_select
      logic            serial_en; // serial_enable
      logic [3:0][1:0] tim_els;   // timer_edge_level_select, B2..B5
      logic            lcd_lo;    // lcd_low_nibble_enable
      logic            lcd_hi;    // lcd_high_nibble_enable
      logic            spi_en;    // spi_enable_bit
   } qio_periph_ctl_s;

   typedef struct packed {
      qio_bus_e        bus;
      logic [3:0][7:0] latch;
      logic [3:0][7:0] dir;
      logic [5:0]      led;
      logic [31:0]     pin_out;
      logic [31:0]     pin_oe;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
   } qio_state_s;

   // ----------------------------------------------------------------
   // one-hot register hit: 0..3 latches, 4..7 directions, 8 led
   // ----------------------------------------------------------------
   function automatic logic [8:0] qio_decode(input logic [11:0] addr);
      logic [8:0] hit;
      hit = '0;
      for (int k = 0; k < 4; k++) begin
         if (addr == OFF_LATCH_BASE + 12'(k * 4)) hit[k] = 1'b1;
         if (addr == OFF_DIR_BASE + 12'(k * 4)) hit[4 + k] = 1'b1;
      end
      if (addr == OFF_LED) hit[8] = 1'b1;
      return hit;
   endfunction

endpackage

// ===== rtl/qio_claim_dec.sv
// Purpose: which pins the on-chip peripherals take over
// Assumes: enables arrive synchronous to the bus clock
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module qio_claim_dec
   import qio_pkg::*;
(
   // peripheral enables
   input  wire qio_periph_ctl_s ctl,
   // pin claim, one bit per pin
   output logic [31:0]          claim
);

   // ----------------------------------------------------------------
   // claim decode per pin group
   // ----------------------------------------------------------------
   always_comb begin
      claim = '0;
      claim[3:0]   = ctl.kbi_en[3:0];
      for (int i = 0; i < 4; i++) begin
         claim[4 + i] = (ctl.adc_sel == ADC_CH_FIRST_A + 5'(i));
      end
      claim[9:8]   = {2{ctl.serial_en}};
      for (int i = 0; i < 4; i++) begin
         claim[10 + i] = (ctl.tim_els[i] != ELS_GPIO);
      end
      for (int i = 0; i < 2; i++) begin
         claim[14 + i] = (ctl.adc_sel == ADC_CH_FIRST_B + 5'(i));
      end
      claim[19:16] = {4{ctl.lcd_lo}};
      claim[23:20] = {4{ctl.lcd_hi}};
      claim[27:24] = {4{ctl.spi_en}};
      claim[31:28] = ctl.kbi_en[7:4];
   end

endmodule // qio_claim_dec
`default_nettype wire

// ===== rtl/qio_port_mux.sv
// Purpose: one 8-bit port: pin drive and read-back selection
// Assumes: claim comes from the peripheral decode
// Notes:   purely combinational, results are registered by the top
`timescale 1ns/100ps
`default_nettype none
module qio_port_mux (
   // port state
   input  wire logic [7:0] latch,
   input  wire logic [7:0] dir,
   // peripheral side
   input  wire logic [7:0] claim,
   input  wire logic [7:0] pout,
   input  wire logic [7:0] poe,
   // pin level
   input  wire logic [7:0] pin_in,
   // results
   output logic      [7:0] nxt_out,
   output logic      [7:0] nxt_oe,
   output logic      [7:0] rd_val
);

   // ----------------------------------------------------------------
   // drive and read-back
   // ----------------------------------------------------------------
   // undriven unclaimed pins show zero, so an unknown latch reaches the pad only once its direction bit is set
   always_comb begin
      nxt_oe  = (claim & poe) | (~claim & dir);
      nxt_out = (claim & pout) | (~claim & dir & latch);
      rd_val  = (dir & latch) | (~dir & pin_in);
   end

endmodule // qio_port_mux
`default_nettype wire

// ===== rtl/qio_ports.sv
// Purpose: four 8-bit bidirectional ports with latch, direction and led control
// Assumes: pin inputs synchronous to CLK; peripherals drive PERIPH_OUT/OE
// Notes:   APB slave, one wait cycle on every access
//
// Functional notes
// - thirty-two two-way pins form four 8-bit ports, each with its own data and direction.
// - every pin is set to input or output on its own by software.
// - port A is 8 bits; pins 0-3 are shared with keyboard inputs and pins 4-7 with converter channels.
// - each port data register holds one output latch bit per pin.
// - the four data registers sit at consecutive indices from the base, then the four directions, led higher up.
// - the led register holds six enables for port B pins 0-5, top two bits read zero, reset clears it.
// - peripheral enables claim pin groups on ports A, B, C and D as listed per group.
// - reset leaves the data latches untouched, so they are unknown after reset.
// - direction one drives the pin, zero releases it; reset makes every pin an input.
// - reading data gives the latch for outputs and the pin level for inputs; writes always load the latch.
// - a claiming peripheral overrides the port's data and direction for that pin.
`timescale 1ns/100ps
`default_nettype none
module qio_ports
   import qio_pkg::*;
(
   // clock and reset
   input  wire logic            CLK,
   input  wire logic            RST_B,
   // apb slave
   input  wire logic            PSEL,
   input  wire logic            PENABLE,
   input  wire logic            PWRITE,
   input  wire logic [11:0]     PADDR,
   input  wire logic [31:0]     PWDATA,
   output logic      [31:0]     PRDATA,
   output logic                 PREADY,
   output logic                 PSLVERR,
   // pins
   input  wire logic [31:0]     PIN_IN,
   output logic      [31:0]     PIN_OUT,
   output logic      [31:0]     PIN_OE,
   // peripheral takeover
   input  wire qio_periph_ctl_s PERIPH_CTL,
   input  wire logic [31:0]     PERIPH_OUT,
   input  wire logic [31:0]     PERIPH_OE,
   // led drive enables for port B 0..5
   output logic      [5:0]      LED_DRIVE
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   qio_state_s  st_ff;
   qio_state_s  nxt_st;
   logic [8:0]  hit;
   logic        access;
   logic        commit;
   logic [31:0] rd_word;
   logic [31:0] claim;
   logic [31:0] mux_out;
   logic [31:0] mux_oe;
   logic [31:0] mux_rd;
   logic [31:0] dir_flat;
   logic [7:0]  mix_c;

   // ----------------------------------------------------------------
   // peripheral claim decode
   // ----------------------------------------------------------------
   qio_claim_dec u_claim (
      .ctl   (PERIPH_CTL),
      .claim (claim)
   );

   // ----------------------------------------------------------------
   // per-port pin logic
   // ----------------------------------------------------------------
   // four identical ports of eight pins each
   for (genvar p = 0; p < 4; p++) begin : g_port
      qio_port_mux u_mux (
         .latch   (st_ff.latch[p]),
         .dir     (st_ff.dir[p]),
         .claim   (claim[p*8 +: 8]),
         .pout    (PERIPH_OUT[p*8 +: 8]),
         .poe     (PERIPH_OE[p*8 +: 8]),
         .pin_in  (PIN_IN[p*8 +: 8]),
         .nxt_out (mux_out[p*8 +: 8]),
         .nxt_oe  (mux_oe[p*8 +: 8]),
         .rd_val  (mux_rd[p*8 +: 8])
      );
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // misaligned or unknown addresses hit nothing and answer with an error
   assign hit    = qio_decode(PADDR);
   assign access = PSEL && PENABLE;
   assign commit = (st_ff.bus == BUS_DONE) && access && PWRITE;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st  = st_ff;
      rd_word = '0;
      // read mux, narrower registers sit in the low bits
      for (int k = 0; k < 4; k++) begin
         if (hit[k]) begin
            rd_word[7:0] = mux_rd[k*8 +: 8];
         end
         if (hit[4 + k]) begin
            rd_word[7:0] = st_ff.dir[k];
         end
      end
      if (hit[8]) begin
         rd_word[LED_LSB +: LED_W] = st_ff.led;
      end
      case (st_ff.bus)
         BUS_IDLE: begin
            if (access) begin
               // pin level is sampled here, one cycle before pready
               nxt_st.bus     = BUS_DONE;
               nxt_st.pready  = 1'b1;
               nxt_st.pslverr = (hit == '0);
               nxt_st.prdata  = PWRITE ? 32'h0000_0000 : rd_word;
            end
         end
         BUS_DONE: begin
            nxt_st.bus     = BUS_IDLE;
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata  = '0;
            // write takes effect at the edge that sees pready high
            if (commit) begin
               for (int k = 0; k < 4; k++) begin
                  if (hit[k]) begin
                     nxt_st.latch[k] = PWDATA[7:0];
                  end
                  if (hit[4 + k]) begin
                     nxt_st.dir[k] = PWDATA[7:0];
                  end
               end
               if (hit[8]) begin
                  nxt_st.led = PWDATA[LED_LSB +: LED_W];
               end
            end
         end
         default: begin
            nxt_st.bus     = BUS_IDLE;
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata  = '0;
         end
      endcase
      // pins follow port state or the claiming peripheral
      nxt_st.pin_out = mux_out;
      nxt_st.pin_oe  = mux_oe;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // latches are left out of reset on purpose, their content survives it
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_ff.bus     <= BUS_IDLE;
         st_ff.dir     <= {4{DIR_RST}};
         st_ff.led     <= LED_RST;
         st_ff.pin_out <= '0;
         st_ff.pin_oe  <= '0;
         st_ff.pready  <= 1'b0;
         st_ff.pslverr <= 1'b0;
         st_ff.prdata  <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign PRDATA    = st_ff.prdata;
   assign PREADY    = st_ff.pready;
   assign PSLVERR   = st_ff.pslverr;
   assign PIN_OUT   = st_ff.pin_out;
   assign PIN_OE    = st_ff.pin_oe;
   assign LED_DRIVE = st_ff.led;

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   assign dir_flat = st_ff.dir;
   assign mix_c    = (st_ff.dir[2] & st_ff.latch[2]) | (~st_ff.dir[2] & PIN_IN[23:16]);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // every answer lasts exactly one cycle
   property p_ready_pulse;
      @(posedge CLK) disable iff (!RST_B)
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready held longer than one cycle");

   // reset clears directions and led enables
   property p_reset_values;
      @(posedge CLK) disable iff (!RST_B)
      $rose(RST_B) |-> (LED_DRIVE == LED_RST) && (dir_flat == '0);
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("direction or led not cleared by reset");

   // a direction write reaches the unclaimed pin enables two edges on
   property p_dir_to_oe;
      @(posedge CLK) disable iff (!RST_B)
      (commit && hit[4]) |=> ##1 (((PIN_OE[7:0] ^ $past(PWDATA[7:0], 2)) & ~$past(claim[7:0])) == 8'h00);
   endproperty
   a_dir_to_oe: assert property (p_dir_to_oe)
      else $error("port A direction write did not reach pin enables");

   // unclaimed pins are enabled exactly by their direction bit
   property p_unclaimed_oe;
      @(posedge CLK) disable iff (!RST_B)
      $past(RST_B) |-> (((PIN_OE ^ $past(dir_flat)) & ~$past(claim)) == '0);
   endproperty
   a_unclaimed_oe: assert property (p_unclaimed_oe)
      else $error("pin enable differs from direction");

   // claimed pins take enable from the peripheral
   property p_claim_override;
      @(posedge CLK) disable iff (!RST_B)
      $past(RST_B) |-> (((PIN_OE ^ $past(PERIPH_OE)) & $past(claim)) == '0);
   endproperty
   a_claim_override: assert property (p_claim_override)
      else $error("claimed pin not handed to peripheral");

   // serial enable hands port B 0-1 to the serial module
   property p_serial_claim;
      @(posedge CLK) disable iff (!RST_B)
      ($past(RST_B) && $past(PERIPH_CTL.serial_en)) |-> (PIN_OE[9:8] == $past(PERIPH_OE[9:8]));
   endproperty
   a_serial_claim: assert property (p_serial_claim)
      else $error("serial enable did not claim port B 0-1");

   // converter channel two selects port A pin 6 only
   property p_adc_claim;
      @(posedge CLK) disable iff (!RST_B)
      (PERIPH_CTL.adc_sel == ADC_CH_FIRST_A + 5'h02) |-> (claim[7:4] == 4'h4);
   endproperty
   a_adc_claim: assert property (p_adc_claim)
      else $error("converter channel claims the wrong port A pin");

   // latch loads whatever the direction
   property p_latch_write;
      @(posedge CLK) disable iff (!RST_B)
      (commit && hit[1]) |=> (st_ff.latch[1] == $past(PWDATA[7:0]));
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("port B latch not loaded by write");

   // data read mixes latch and pin level by direction
   property p_read_mix;
      @(posedge CLK) disable iff (!RST_B)
      ($rose(PREADY) && $past(hit[2]) && !$past(PWRITE)) |-> (PRDATA == {24'h000000, $past(mix_c)});
   endproperty
   a_read_mix: assert property (p_read_mix)
      else $error("port C read value wrong");

   // led register reads six bits, upper bits zero
   property p_led_read;
      @(posedge CLK) disable iff (!RST_B)
      ($rose(PREADY) && $past(hit[8]) && !$past(PWRITE)) |-> (PRDATA == {26'h0000000, $past(LED_DRIVE)});
   endproperty
   a_led_read: assert property (p_led_read)
      else $error("led register read wrong");

   // unmapped address answers with error and zero data
   property p_unmapped;
      @(posedge CLK) disable iff (!RST_B)
      $rose(PREADY) |-> (PSLVERR == ($past(hit) == '0)) && (!PSLVERR || PRDATA == '0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("address decode answer wrong");

   // an error only comes with an answer
   property p_err_with_ready;
      @(posedge CLK) disable iff (!RST_B)
      PSLVERR |-> PREADY;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error flag without ready");

   // read data is zero outside the answer cycle
   property p_rdata_idle;
      @(posedge CLK) disable iff (!RST_B)
      !PREADY |-> (PRDATA == '0);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data left on the bus");

   // the first access cycle is always answered at the next edge
   property p_access_answer;
      @(posedge CLK) disable iff (!RST_B)
      (PSEL && PENABLE && !PREADY) |=> PREADY;
   endproperty
   a_access_answer: assert property (p_access_answer)
      else $error("access not answered in one cycle");

   // led write keeps only the six enables
   property p_led_write;
      @(posedge CLK) disable iff (!RST_B)
      (commit && hit[8]) |=> (LED_DRIVE == $past(PWDATA[LED_LSB +: LED_W]));
   endproperty
   a_led_write: assert property (p_led_write)
      else $error("led enables not loaded by write");

   // port C direction write lands whole
   property p_dir_write;
      @(posedge CLK) disable iff (!RST_B)
      (commit && hit[6]) |=> (st_ff.dir[2] == $past(PWDATA[7:0]));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("port C direction not loaded by write");

   // a refused write leaves directions and led enables alone
   property p_bad_write_ignored;
      @(posedge CLK) disable iff (!RST_B)
      (commit && (hit == '0)) |=> ($stable(dir_flat) && $stable(LED_DRIVE));
   endproperty
   a_bad_write_ignored: assert property (p_bad_write_ignored)
      else $error("unmapped write changed a register");

   // spi enable hands port D 0-3 to the spi module
   property p_spi_claim;
      @(posedge CLK) disable iff (!RST_B)
      ($past(RST_B) && $past(PERIPH_CTL.spi_en)) |-> (PIN_OE[27:24] == $past(PERIPH_OE[27:24]));
   endproperty
   a_spi_claim: assert property (p_spi_claim)
      else $error("spi enable did not claim port D 0-3");

   // claimed pins take their level from the peripheral
   property p_claim_out;
      @(posedge CLK) disable iff (!RST_B)
      $past(RST_B) |-> (((PIN_OUT ^ $past(PERIPH_OUT)) & $past(claim)) == '0);
   endproperty
   a_claim_out: assert property (p_claim_out)
      else $error("claimed pin level not from peripheral");

endmodule // qio_ports
`default_nettype wire

// ===== testbench/qio_pad_model.sv
// Purpose: far-side model of the 32 pads seen by the port block
// Assumes: a pad the block releases shows the level the bench sets on ext
// Notes:   no pull resistors modelled, so ext always defines a free pad
`timescale 1ns/100ps
`default_nettype none
module qio_pad_model (
   // block side
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   // outside world
   input  wire logic [31:0] ext,
   // resolved pad level
   output logic      [31:0] pad
);
   // ----------------------------------------------------------------
   // pad resolution
   // ----------------------------------------------------------------
   // driven pads follow the block, released pads the outside level
   assign pad = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // qio_pad_model
`default_nettype wire

// ===== testbench/qio_ports_tb.sv
// Purpose: self-checking bench for the quad parallel port block
// Assumes: apb answers in the cycle after the first access cycle
// Notes:   pad levels come from qio_pad_model, peripherals from the bench
`timescale 1ns/100ps
`default_nettype none
module qio_ports_tb
   import qio_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus tables
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [7:0]  x;
      logic        e;
   } qio_row_s;
   // adc code 0x1f claims no pin
   localparam qio_periph_ctl_s CTL_NONE = '{8'h00, 5'h1f, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0};
   localparam logic [31:0] BASE_OE  = 32'hf00f_a55a;
   localparam logic [31:0] BASE_OUT = 32'ha005_8412;
   qio_row_s rows [12] = '{
      '{1'b1, 12'h010, 32'hffff_ff5a, 8'h5a, 1'b0}, '{1'b1, 12'h014, 32'h0000_00a5, 8'ha5, 1'b0},
      '{1'b1, 12'h018, 32'h0000_000f, 8'h0f, 1'b0}, '{1'b1, 12'h01c, 32'h0000_00f0, 8'hf0, 1'b0},
      '{1'b1, 12'h000, 32'h0000_0033, 8'h93, 1'b0}, '{1'b1, 12'h004, 32'h0000_00cc, 8'h9c, 1'b0},
      '{1'b1, 12'h008, 32'h0000_0055, 8'h65, 1'b0}, '{1'b1, 12'h00c, 32'h0000_00aa, 8'ha6, 1'b0},
      '{1'b1, 12'h030, 32'h0000_00ff, 8'h3f, 1'b0}, '{1'b1, 12'h031, 32'h0000_00ff, 8'h00, 1'b1},
      '{1'b1, 12'h020, 32'h0000_00ff, 8'h00, 1'b1}, '{1'b0, 12'h030, 32'h0000_0000, 8'h3f, 1'b0}};
   qio_periph_ctl_s sets [3] = '{
      '{8'h00, 5'h06, 1'b1, 8'h01, 1'b1, 1'b0, 1'b1},
      '{8'hff, 5'h05, 1'b0, 8'h6c, 1'b0, 1'b1, 1'b0},
      '{8'h00, 5'h02, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0}};
   // converter channel two claims port A pin 6 alone
   logic [31:0] masks [3] = '{32'h0f0f_0700, 32'hf0f0_b80f, 32'h0000_0040};

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic            clk = 1'b0;
   logic            rst_b, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0]     paddr;
   logic [31:0]     pwdata, prdata, pin_in, pin_out, pin_oe, p_out, p_oe, ext, rd;
   logic [5:0]      led;
   qio_periph_ctl_s ctl;
   int              num_errors, n_compared;

   // ----------------------------------------------------------------
   // design and pad model
   // ----------------------------------------------------------------
   qio_ports u_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PERIPH_CTL(ctl),
      .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .LED_DRIVE(led));
   qio_pad_model u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pad(pin_in));

   // 10 MHz bus clock
   always #50 clk = ~clk;

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // one apb transfer, waits for pready as long as it takes, the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // pins settle one edge after their cause, three edges leave margin
   task automatic pins(input logic [31:0] oe, input logic [31:0] out);
      repeat (3) @(posedge clk);
      chk(pin_oe, oe, "pin enable");
      chk(pin_out, out, "pin value");
   endtask

   task automatic conclude();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; ctl = CTL_NONE;
      p_out = 32'h5555_5555; p_oe = 32'h0fff_7f00; ext = 32'h9669_3cc3;
      repeat (16) @(posedge clk);
      chk({26'h0, led}, 32'h0, "led in reset");
      chk(pin_oe, 32'h0, "enable in reset");
      rst_b <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, (k < 4) ? OFF_DIR_BASE + 12'(k * 4) : OFF_LED, 32'h0);
         chk(rd, 32'h0, "register after reset");
      end
      // write each row marked as a write, then read back every row
      foreach (rows[i]) begin
         if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
         if (rows[i].wr) chk({31'h0, er}, {31'h0, rows[i].e}, "write error flag");
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, {24'h0, rows[i].x}, "read data");
         chk({31'h0, er}, {31'h0, rows[i].e}, "read error flag");
      end
      pins(BASE_OE, BASE_OUT);
      chk({26'h0, led}, 32'h3f, "led drive");
      // peripheral takeover of each pin group
      for (int k = 0; k < 3; k++) begin
         ctl <= sets[k];
         pins((masks[k] & p_oe) | (~masks[k] & BASE_OE), (masks[k] & p_out) | (~masks[k] & BASE_OUT));
      end
      // reset in mid-run keeps the latches
      ctl <= CTL_NONE;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      chk(pin_oe, 32'h0, "enable after second reset");
      chk({26'h0, led}, 32'h0, "led after second reset");
      rst_b <= 1'b1;
      apb(1'b1, OFF_DIR_BASE, 32'h0000_00ff);
      apb(1'b0, OFF_LATCH_BASE, 32'h0);
      chk(rd, 32'h0000_0033, "latch kept over reset");
      pins(32'h0000_00ff, 32'h0000_0033);
      conclude();
   end

   // watchdog, the sequence needs fewer than two hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
endmodule // qio_ports_tb
`default_nettype wire
